// ---- verilog/fail_safe_clock_monitor.sv ----
// What this block does
// - Sample clock is low-frequency oscillator divided 64.
// - Monitored clock falling edge sets detector latch.
// - Sample clock rising edge clears detector latch.
// - Failure after full sample half-period without low.
// - Failure switches to internal source, sets flag.
// - Interrupt request needs flag and enable both.
// - No automatic return to failed external clock.
// - Fallback frequency comes from internal frequency select.
// - Reset or select-bit toggle clears, restarts timer.
// - Timer expiry clears failure, returns to external.
// - Flag clearable regardless of fail-safe state.
// - Detection armed only after start-up timer expires.
// - Timer runs after wake-up and every reset.
// - External-clock and RC modes skip the timer.
// - Monitor enable forces two-speed start-up on.
// - Start-up timer expires after 1024 input oscillations.
// - Monitor works only when its enable bit set.
// - Status bit one on primary, zero on internal.
`timescale 1ns/10ps
module fail_safe_clock_monitor
    import fsm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator side.
    input wire logic low_freq_tick,
    input wire logic oscillator_input,
    input wire logic wake_from_sleep,
    // System clock steering.
    output logic use_internal,
    output logic [2:0] internal_freq_select,
    output logic cpu_hold,
    output logic osc_fail_irq
);

    // ========================================================================
    // Register storage.
    // ========================================================================
    logic [7:0] cfg_q;
    logic [7:0] osc_ctl_q;
    logic osc_fail_int_enable_q;
    logic osc_fail_flag_q;
    monitor_state_e state_q;
    logic [10:0] startup_cnt_q;
    logic osc_prev_q;
    logic [2:0] fallback_freq_q;
    logic use_internal_q;
    logic cpu_hold_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    monitor_cfg_s cfg;
    monitor_sts_s sts;
    logic failure;
    logic bus_wr;
    logic bus_rd;
    logic src_toggle;
    logic restart;
    logic osc_fall;
    logic addr_ok;

    // ========================================================================
    // Configuration decode.
    // ========================================================================
    // Two-speed start-up is forced on whenever the monitor is enabled.
    always_comb begin
        cfg.fail_monitor_enable = cfg_q[CFG_FAIL_MON_BIT];
        cfg.two_speed_enable = cfg_q[CFG_TWO_SPEED_BIT]
                               || cfg_q[CFG_FAIL_MON_BIT];
        cfg.skip_startup = (cfg_q[3:0] == MODE_EXT_CLOCK)
                           || (cfg_q[3:0] == MODE_RES_CAP);
        cfg.internal_freq_select = osc_ctl_q[OSC_FREQ_LSB +: 3];
    end

    // ========================================================================
    // APB access.
    // ========================================================================
    // Each access completes in its second access cycle; pready is registered,
    // so the slave answers one cycle into the access phase.
    assign bus_wr = psel && penable && pwrite && !pready_q;
    assign bus_rd = psel && penable && !pwrite && !pready_q;
    assign addr_ok = (paddr == ADDR_CLOCK_CONFIG_HIGH)
                     || (paddr == ADDR_OSCILLATOR_CONTROL)
                     || (paddr == ADDR_PERIPHERAL_INT_ENABLE_TWO)
                     || (paddr == ADDR_PERIPHERAL_INT_FLAGS_TWO)
                     || (paddr == ADDR_CONTROL_EXTRA);

    // A software toggle of the upper source select bit.
    assign src_toggle = bus_wr && (paddr == ADDR_OSCILLATOR_CONTROL)
                        && (pwdata[OSC_SRC_HI_BIT]
                            != osc_ctl_q[OSC_SRC_HI_BIT]);

    // Wake-up pulse, software toggle and a write setting the wake bit of the extra control register.
    assign restart = src_toggle || wake_from_sleep
                     || (bus_wr && (paddr == ADDR_CONTROL_EXTRA)
                         && pwdata[CTL_SLEEP_WAKE_BIT]);

    // Configuration register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= CLOCK_CONFIG_RESET;
        end else if (bus_wr && paddr == ADDR_CLOCK_CONFIG_HIGH) begin
            cfg_q <= pwdata[7:0];
        end
    end

    // Oscillator control; the status bit is read-only and not stored here.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_ctl_q <= OSC_CONTROL_RESET;
        end else if (bus_wr && paddr == ADDR_OSCILLATOR_CONTROL) begin
            osc_ctl_q <= pwdata[7:0] & ~(8'h01 << OSC_STATUS_BIT);
        end
    end

    // Interrupt enable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_fail_int_enable_q <= 1'b0;
        end else if (bus_wr && paddr == ADDR_PERIPHERAL_INT_ENABLE_TWO) begin
            osc_fail_int_enable_q <= pwdata[INT_FAIL_BIT];
        end
    end

    // Fail flag: set by a failure, cleared by writing zero at any time.
    // A failure in the clearing cycle wins over the clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_fail_flag_q <= 1'b0;
        end else if (sts.fail_event) begin
            osc_fail_flag_q <= 1'b1;
        end else if (bus_wr && paddr == ADDR_PERIPHERAL_INT_FLAGS_TWO) begin
            osc_fail_flag_q <= pwdata[INT_FAIL_BIT];
        end
    end

    // Read data and bus answer; unmapped addresses answer with pslverr.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !addr_ok;
            if (bus_rd) begin
                unique case (paddr)
                    ADDR_CLOCK_CONFIG_HIGH: begin
                        prdata_q <= {24'h000000, cfg_q};
                    end
                    ADDR_OSCILLATOR_CONTROL: begin
                        prdata_q <= {24'h000000, osc_ctl_q
                            | ({7'h00, sts.startup_done && !use_internal_q}
                               << OSC_STATUS_BIT)};
                    end
                    ADDR_PERIPHERAL_INT_ENABLE_TWO: begin
                        prdata_q <= {24'h000000,
                            {osc_fail_int_enable_q, 7'h00}};
                    end
                    ADDR_PERIPHERAL_INT_FLAGS_TWO: begin
                        prdata_q <= {24'h000000, {osc_fail_flag_q, 7'h00}};
                    end
                    default: begin
                        prdata_q <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ========================================================================
    // Start-up timer and fail-safe state.
    // ========================================================================
    assign osc_fall = osc_prev_q && !oscillator_input;

    // Previous level of the external clock for counting oscillations.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= oscillator_input;
        end
    end

    // Count external oscillations while in start-up; restart on demand.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startup_cnt_q <= 11'h000;
        end else if (restart) begin
            startup_cnt_q <= 11'h000;
        end else if (state_q == ST_STARTUP && osc_fall
                     && startup_cnt_q != STARTUP_COUNT) begin
            startup_cnt_q <= startup_cnt_q + 11'h001;
        end
    end

    // State: start-up, running on the external clock, failed.
    // Only a restart leaves the failed state; it never times out alone.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_STARTUP;
        end else if (restart) begin
            state_q <= ST_STARTUP;
        end else begin
            unique case (state_q)
                ST_STARTUP: begin
                    if (cfg.skip_startup
                        || startup_cnt_q == STARTUP_COUNT) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (failure) begin
                        state_q <= ST_FAILED;
                    end
                end
                ST_FAILED: begin
                    state_q <= ST_FAILED;
                end
                default: begin
                    state_q <= ST_STARTUP;
                end
            endcase
        end
    end

    // Status bundle seen by the register file.
    always_comb begin
        sts.failed = (state_q == ST_FAILED);
        sts.startup_done = (state_q == ST_RUN);
        sts.use_internal = (state_q != ST_RUN);
        sts.fail_event = (state_q == ST_RUN) && failure;
    end

    // Detection is armed only in the running state with the monitor on.
    fail_detector u_detector (
        .clk(clk),
        .rst_n(rst_n),
        .low_freq_tick(low_freq_tick),
        .oscillator_input(oscillator_input),
        .armed((state_q == ST_RUN)
               && cfg.fail_monitor_enable),
        .sample_rise(),
        .failure(failure)
    );

    // ========================================================================
    // Clock steering outputs.
    // ========================================================================
    // Internal source during start-up and after a failure.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            use_internal_q <= 1'b1;
        end else begin
            use_internal_q <= (state_q != ST_RUN && !restart
                               && !(state_q == ST_STARTUP
                                    && (cfg.skip_startup
                                    || startup_cnt_q == STARTUP_COUNT)))
                              || (state_q == ST_RUN && failure)
                              || restart;
        end
    end

    // The fallback frequency follows the register every cycle, so software
    // can set it up before a failure and still retune it afterwards.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fallback_freq_q <= OSC_CONTROL_RESET[OSC_FREQ_LSB +: 3];
        end else begin
            fallback_freq_q <= cfg.internal_freq_select;
        end
    end

    // Without two-speed start-up the core waits for the timer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_hold_q <= 1'b0;
        end else begin
            cpu_hold_q <= (state_q == ST_STARTUP) && !cfg.two_speed_enable
                          && !cfg.skip_startup;
        end
    end

    // Interrupt request needs both flag and enable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= osc_fail_flag_q && osc_fail_int_enable_q;
        end
    end

    assign use_internal = use_internal_q;
    assign internal_freq_select = fallback_freq_q;
    assign cpu_hold = cpu_hold_q;
    assign osc_fail_irq = irq_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule // fail_safe_clock_monitor

// ---- verilog/fsm_pkg.sv ----
package fsm_pkg;

    // ========================================================================
    // Register map, byte addresses on the APB.
    // ========================================================================
    localparam logic [7:0] ADDR_CLOCK_CONFIG_HIGH = 8'h00;
    localparam logic [7:0] ADDR_OSCILLATOR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_PERIPHERAL_INT_ENABLE_TWO = 8'h08;
    localparam logic [7:0] ADDR_PERIPHERAL_INT_FLAGS_TWO = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL_EXTRA = 8'h10;

    // ========================================================================
    // Field positions.
    // ========================================================================
    localparam int CFG_TWO_SPEED_BIT = 7;
    localparam int CFG_FAIL_MON_BIT = 6;
    localparam int CFG_MODE_LSB = 0;
    localparam int OSC_FREQ_LSB = 4;
    localparam int OSC_STATUS_BIT = 3;
    localparam int OSC_SRC_HI_BIT = 1;
    localparam int OSC_SRC_LO_BIT = 0;
    localparam int INT_FAIL_BIT = 7;
    localparam int CTL_SLEEP_WAKE_BIT = 0;

    // ========================================================================
    // Reset values.
    // ========================================================================
    localparam logic [7:0] CLOCK_CONFIG_RESET = 8'hC0;
    localparam logic [7:0] OSC_CONTROL_RESET = 8'h30;

    // ========================================================================
    // Oscillator mode codes held in the low nibble of the config register.
    // ========================================================================
    localparam logic [3:0] MODE_EXT_CLOCK = 4'h4;
    localparam logic [3:0] MODE_RES_CAP = 4'h6;

    // ========================================================================
    // Counts of cycles.
    // ========================================================================
    localparam int SAMPLE_DIVIDE = 64;
    localparam logic [5:0] SAMPLE_HALF_LAST = 6'h1F;
    localparam logic [10:0] STARTUP_COUNT = 11'h400;

    // Software-facing configuration that travels into the monitor core.
    typedef struct packed {
        logic fail_monitor_enable;
        logic two_speed_enable;
        logic skip_startup;
        logic [2:0] internal_freq_select;
    } monitor_cfg_s;

    // Status that the monitor core reports back.
    typedef struct packed {
        logic use_internal;
        logic failed;
        logic startup_done;
        logic fail_event;
    } monitor_sts_s;

    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_RUN = 2'b01,
        ST_FAILED = 2'b11
    } monitor_state_e;

endpackage

// ---- verilog/fail_detector.sv ----
`timescale 1ns/10ps
module fail_detector
    import fsm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Low-frequency oscillator tick and monitored clock level.
    input wire logic low_freq_tick,
    input wire logic oscillator_input,
    input wire logic armed,
    // Result.
    output logic sample_rise,
    output logic failure
);

    // ========================================================================
    // Sample clock divider.
    // ========================================================================
    logic [5:0] div_q;
    logic osc_q;
    logic seen_low_q;

    // Divide the low-frequency ticks by 64 to form the sample clock.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 6'h00;
        end else if (low_freq_tick) begin
            div_q <= div_q + 6'h01;
        end
    end

    // Rising edge of the sample clock: wrap to zero; half period ends at 31.
    assign sample_rise = low_freq_tick && (div_q == 6'h3F);

    // Previous level of the monitored clock for falling edge detection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= oscillator_input;
        end
    end

    // The latch: set on a falling edge, cleared on a sample rising edge.
    // Set wins so that an edge in the clearing cycle is never lost.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_low_q <= 1'b0;
        end else if (osc_q && !oscillator_input) begin
            seen_low_q <= 1'b1;
        end else if (sample_rise) begin
            seen_low_q <= 1'b0;
        end
    end

    // A whole high half of the sample clock without a falling edge fails.
    assign failure = armed && low_freq_tick && (div_q == SAMPLE_HALF_LAST)
        && !seen_low_q && !(osc_q && !oscillator_input);

endmodule // fail_detector

// ---- test/osc_model.sv ----
`timescale 1ns/10ps
// ======================================================================
// External crystal and the free-running low-frequency tick.
module osc_model #(
    parameter int TICK_DIV = 4
) (
    // Clock.
    input wire logic clk,
    // Crystal gate: low models a dead crystal.
    input wire logic run,
    // Oscillator outputs.
    output logic oscillator_input = 1'b1,
    output logic low_freq_tick = 1'b0
);
    int div = 0;
    // A dead crystal sticks high, so the detector never sees it go low.
    always @(posedge clk) begin
        oscillator_input <= run ? !oscillator_input : 1'b1;
        div <= (div == TICK_DIV - 1) ? 0 : div + 1;
        low_freq_tick <= (div == TICK_DIV - 1);
    end
endmodule // osc_model

// ---- test/fsm_props.sv ----
`timescale 1ns/10ps
// ======================================================================
// Port-level checks for the clock monitor.
module fsm_props
    import fsm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Oscillator side.
    input wire logic low_freq_tick,
    input wire logic oscillator_input,
    input wire logic wake_from_sleep,
    // Clock steering.
    input wire logic use_internal,
    input wire logic [2:0] internal_freq_select,
    input wire logic cpu_hold,
    input wire logic osc_fail_irq
);
    logic en_q, mon_q, two_q, skip_q, scs_q, osc_q;
    logic [2:0] freq_q, quiet_q;
    logic [10:0] falls_q;
    logic [6:0] ticks_q;
    wire logic wr = psel && penable && pwrite && !pready;
    wire logic wr_osc = wr && paddr == ADDR_OSCILLATOR_CONTROL;
    wire logic fall = osc_q && !oscillator_input;
    wire logic restart = wake_from_sleep || (wr_osc && pwdata[1] != scs_q)
        || (wr && paddr == ADDR_CONTROL_EXTRA && pwdata[0]);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ==================================================================
    // Mirror of the software settings as written over the bus.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {en_q, mon_q, two_q, skip_q, scs_q} <= 5'h0C;
            freq_q <= 3'h3;
        end else if (wr && paddr == ADDR_PERIPHERAL_INT_ENABLE_TWO) begin
            en_q <= pwdata[INT_FAIL_BIT];
        end else if (wr && paddr == ADDR_CLOCK_CONFIG_HIGH) begin
            mon_q <= pwdata[6];
            two_q <= pwdata[7] || pwdata[6];
            skip_q <= pwdata[3:0] == MODE_EXT_CLOCK
                || pwdata[3:0] == MODE_RES_CAP;
        end else if (wr_osc) begin
            scs_q <= pwdata[1];
            freq_q <= pwdata[6:4];
        end
    end
    // Counters saturate so that a long run can never wrap into a pass.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_q <= 1'b1;
            falls_q <= 11'h000;
            ticks_q <= 7'h00;
            quiet_q <= 3'h0;
        end else begin
            osc_q <= oscillator_input;
            falls_q <= restart ? 11'h000
                : falls_q + 11'(fall && falls_q != 11'h7FF);
            ticks_q <= fall ? 7'h00
                : ticks_q + 7'(low_freq_tick && ticks_q != 7'h7F);
            quiet_q <= restart ? 3'h0 : quiet_q + 3'(quiet_q != 3'h7);
        end
    end
    // ==================================================================
    // Assertions.
    AST_ANSWER: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered");
    AST_ONE_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_REFUSED: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without zero data");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_IRQ_GATED: assert property (osc_fail_irq |-> $past(en_q))
        else $error("interrupt raised while disabled");
    AST_FREQ: assert property (
        wr_osc |=> ##[0:2] internal_freq_select == freq_q)
        else $error("fallback frequency not taken from register");
    AST_TWO_SPEED: assert property (cpu_hold |-> !$past(two_q))
        else $error("core held although two-speed start is forced");
    AST_FAIL_TIME: assert property (
        $rose(use_internal) && quiet_q == 3'h7
        |-> ticks_q >= 7'h1F && $past(mon_q))
        else $error("failure declared too early or while disabled");
    AST_STARTUP: assert property (
        $fell(use_internal) |-> falls_q >= 11'h3FF || skip_q)
        else $error("left internal clock before start-up count");
    cover property ($rose(use_internal) && quiet_q == 3'h7);
    cover property ($fell(use_internal) && !skip_q);
    cover property (pslverr);
    cover property (cpu_hold);
endmodule // fsm_props

// ---- test/tb.sv ----
`timescale 1ns/10ps
// ======================================================================
// Bench: register walk from a table, then the clock-failure cases.
module tb
    import fsm_pkg::*;
;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic err;
    } row_s;
    // Reset values, a refused place, then the set-up writes.
    localparam row_s ROWS [10] = '{
    '{1'b0, 8'h00, 32'h0, 32'hC0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h30, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h00, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h00, 1'b0},
    '{1'b1, 8'h14, 32'hFF, 32'h0, 1'b1}, '{1'b0, 8'h14, 32'h0, 32'h00, 1'b1},
    '{1'b1, 8'h00, 32'h40, 32'h0, 1'b0}, '{1'b1, 8'h04, 32'h50, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h50, 1'b0}, '{1'b1, 8'h08, 32'h80, 32'h0, 1'b0}
    };
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic wake_from_sleep = 1'b0, run = 1'b1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, low_freq_tick, oscillator_input, er;
    logic use_internal, cpu_hold, osc_fail_irq;
    logic [2:0] internal_freq_select;
    int fail_count = 0, checked = 0, cycles = 0;
    fail_safe_clock_monitor uut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_freq_tick(low_freq_tick), .oscillator_input(oscillator_input),
        .wake_from_sleep(wake_from_sleep), .use_internal(use_internal),
        .internal_freq_select(internal_freq_select), .cpu_hold(cpu_hold),
        .osc_fail_irq(osc_fail_irq));
    osc_model u_osc (.clk(clk), .run(run),
        .oscillator_input(oscillator_input), .low_freq_tick(low_freq_tick));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // ==================================================================
    // Shared tasks.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk_b(er, 1'b0);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
        chk_b(er, 1'b0);
    endtask
    // Bounded wait for the clock steering to settle, then compare it.
    task automatic wait_int(input logic v, input int lim);
        for (int n = 0; n < lim && use_internal !== v; n++) @(posedge clk);
        chk_b(use_internal, v);
    endtask
    task automatic wake();
        wake_from_sleep <= 1'b1;
        @(posedge clk);
        wake_from_sleep <= 1'b0;
        @(posedge clk);
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // A hang counts as a mismatch and still reaches the verdict.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            close_out();
        end
    end
    // ==================================================================
    // Main sequence.
    initial begin
        repeat (3) @(posedge clk);
        chk({29'h0, internal_freq_select}, 32'h3);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].w) chk(rd, ROWS[i].e);
            chk_b(er, ROWS[i].err);
        end
        chk({29'h0, internal_freq_select}, 32'h5);
        chk_b(cpu_hold, 1'b0);
        repeat (1800) @(posedge clk);
        chk_b(use_internal, 1'b1);
        wait_int(1'b0, 600);
        rdchk(ADDR_OSCILLATOR_CONTROL, 32'h58);
        run <= 1'b0;
        repeat (100) @(posedge clk);
        chk_b(use_internal, 1'b0);
        wait_int(1'b1, 600);
        repeat (3) @(posedge clk);
        chk_b(osc_fail_irq, 1'b1);
        rdchk(ADDR_PERIPHERAL_INT_FLAGS_TWO, 32'h80);
        run <= 1'b1;
        repeat (2400) @(posedge clk);
        chk_b(use_internal, 1'b1);
        wr(ADDR_PERIPHERAL_INT_ENABLE_TWO, 32'h0);
        chk_b(osc_fail_irq, 1'b0);
        wr(ADDR_PERIPHERAL_INT_ENABLE_TWO, 32'h80);
        wr(ADDR_PERIPHERAL_INT_FLAGS_TWO, 32'h0);
        chk_b(osc_fail_irq, 1'b0);
        rdchk(ADDR_OSCILLATOR_CONTROL, 32'h50);
        wr(ADDR_OSCILLATOR_CONTROL, 32'h52);
        wr(ADDR_OSCILLATOR_CONTROL, 32'h50);
        repeat (1800) @(posedge clk);
        chk_b(use_internal, 1'b1);
        wait_int(1'b0, 600);
        wake();
        rdchk(ADDR_OSCILLATOR_CONTROL, 32'h50);
        chk_b(use_internal, 1'b1);
        wait_int(1'b0, 2400);
        wr(ADDR_CLOCK_CONFIG_HIGH, 32'h44);
        wake();
        rdchk(ADDR_OSCILLATOR_CONTROL, 32'h58);
        wr(ADDR_CLOCK_CONFIG_HIGH, 32'h46);
        wake();
        rdchk(ADDR_OSCILLATOR_CONTROL, 32'h58);
        run <= 1'b0;
        wait_int(1'b1, 600);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk_b(use_internal, 1'b1);
        rst_n <= 1'b1;
        run <= 1'b1;
        @(posedge clk);
        rdchk(ADDR_PERIPHERAL_INT_FLAGS_TWO, 32'h0);
        wait_int(1'b0, 2400);
        wr(ADDR_CLOCK_CONFIG_HIGH, 32'h00);
        run <= 1'b0;
        repeat (600) @(posedge clk);
        chk_b(use_internal, 1'b0);
        wr(ADDR_CONTROL_EXTRA, 32'h1);
        repeat (3) @(posedge clk);
        chk_b(cpu_hold, 1'b1);
        close_out();
    end
endmodule // tb

bind fail_safe_clock_monitor fsm_props u_props (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_freq_tick(low_freq_tick), .oscillator_input(oscillator_input),
    .wake_from_sleep(wake_from_sleep), .use_internal(use_internal),
    .internal_freq_select(internal_freq_select), .cpu_hold(cpu_hold),
    .osc_fail_irq(osc_fail_irq));
